// ==== inc/codec_regs_pkg.sv ====
package codec_regs_pkg;

   // ****************************************************************
   // Command and register addresses on the serial control bus
   // ****************************************************************
   localparam logic [7:0] ADDR_GLOBAL_CLEAR               = 8'h01;
   localparam logic [7:0] ADDR_FILTER_BANDWIDTH_CONTROL   = 8'h61;
   localparam logic [7:0] ADDR_OUTPUT_GAIN_AND_SIDETONE   = 8'h62;
   localparam logic [7:0] ADDR_PROCESS_STATUS             = 8'h80;
   localparam logic [7:0] ADDR_DECODER_VOICE_ACTIVITY     = 8'hD4;
   localparam logic [7:0] ADDR_DECODER_OFFSET_RESULT      = 8'hD5;
   localparam logic [7:0] ADDR_DECODER_LINEAR_SAMPLE_OUT  = 8'hD6;
   localparam logic [7:0] ADDR_DECODER_DELTA_MOD_OUT      = 8'hDA;
   localparam logic [7:0] ADDR_ENCODER_VOICE_ACTIVITY     = 8'hE4;
   localparam logic [7:0] ADDR_ENCODER_OFFSET_RESULT      = 8'hE5;
   localparam logic [7:0] ADDR_ENCODER_LINEAR_SAMPLE_OUT  = 8'hE6;
   localparam logic [7:0] ADDR_ENCODER_DELTA_MOD_OUT      = 8'hEA;

   // ****************************************************************
   // Field positions of the filter bandwidth register
   // ****************************************************************
   localparam int FBW_AAF_BYPASS_BIT = 7;
   localparam int FBW_AAF_CUT_MSB    = 6;
   localparam int FBW_AAF_CUT_LSB    = 4;
   localparam int FBW_AIF_BYPASS_BIT = 3;
   localparam int FBW_AIF_CUT_MSB    = 2;
   localparam int FBW_AIF_CUT_LSB    = 0;

   // ****************************************************************
   // Field positions of the output gain and sidetone register
   // ****************************************************************
   localparam int OGS_VOLUME_MSB      = 7;
   localparam int OGS_VOLUME_LSB      = 3;
   localparam int OGS_SIDETONE_MSB    = 2;
   localparam int OGS_SIDETONE_LSB    = 1;
   localparam int OGS_SIDETONE_EN_BIT = 0;
   localparam logic [4:0] VOLUME_MUTE_CODE = 5'h00;

   // ****************************************************************
   // Reset values and framing counts
   // ****************************************************************
   localparam logic [7:0] WRITE_ONLY_RESET = 8'h00;
   localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;

   // Frame phases, Gray coded in the order address, write, read, skip.
   typedef enum logic [1:0] {
      phase_addr  = 2'b00,
      phase_write = 2'b01,
      phase_read  = 2'b11,
      phase_skip  = 2'b10
   } phase_e;

endpackage

// ==== inc/serial_link_if.sv ====
`timescale 1ns/100ps
interface serial_link_if;
   logic       byte_valid;   // One-cycle pulse on the eighth rising serial clock edge.
   logic [7:0] rx_byte;      // Byte just received, MSB first.
   logic       frame_active; // Select is asserted, after synchronising.
   logic       tx_load;      // Load tx_byte for shifting out.
   logic [7:0] tx_byte;

   modport shifter (
      output byte_valid,
      output rx_byte,
      output frame_active,
      input  tx_load,
      input  tx_byte
   );

   modport decoder (
      input  byte_valid,
      input  rx_byte,
      input  frame_active,
      output tx_load,
      output tx_byte
   );
endinterface

// ==== hw/serial_shifter.sv ====
`timescale 1ns/100ps
module serial_shifter
   import codec_regs_pkg::*;
(
   input  wire logic    mclk,
   input  wire logic    rst_b,
   input  wire logic    serial_clk,
   input  wire logic    select_b,
   input  wire logic    cmd_in,
   output logic         reply_out,
   serial_link_if.shifter link
);

   typedef struct packed {
      logic [2:0] sync1;    // First synchroniser stage: clk, select_b, data.
      logic [2:0] sync2;    // Second synchroniser stage.
      logic       clk_prev; // Serial clock one cycle back, for edge finding.
      logic [6:0] rx;
      logic [2:0] bit_cnt;
      logic [7:0] tx;
      logic       dout;
   } shift_s;

   shift_s st;
   shift_s next_st;
   logic   clk_rise;
   logic   clk_fall;

   // ****************************************************************
   // Edge finding on the synchronised serial clock
   // ****************************************************************
   assign clk_rise = st.sync2[2] & ~st.clk_prev;
   assign clk_fall = ~st.sync2[2] & st.clk_prev;

   // The byte is offered combinationally so the reply can be loaded well
   // before the next falling edge; the half period is only four cycles.
   assign link.frame_active = ~st.sync2[1];
   assign link.byte_valid   = link.frame_active & clk_rise & (st.bit_cnt == LAST_BIT_OF_BYTE);
   assign link.rx_byte      = {st.rx, st.sync2[0]};
   assign reply_out         = st.dout;

   // ****************************************************************
   // Receive and transmit shifting
   // ****************************************************************
   always_comb begin
      next_st          = st;
      next_st.sync1    = {serial_clk, select_b, cmd_in};
      next_st.sync2    = st.sync1;
      next_st.clk_prev = st.sync2[2];
      if (!link.frame_active) begin
         next_st.bit_cnt = 3'h0;
         next_st.tx      = 8'h00;
         next_st.dout    = 1'b0;
      end else begin
         if (clk_rise) begin
            next_st.rx      = {st.rx[5:0], st.sync2[0]};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
         end
         // A load lands in the cycle of the last rising edge, so it never
         // meets a falling edge in the same cycle.
         if (link.tx_load) begin
            next_st.tx = link.tx_byte;
         end else if (clk_fall) begin
            next_st.dout = st.tx[7];
            next_st.tx   = {st.tx[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{sync1: 3'h2, sync2: 3'h2, default: '0};
      end else begin
         st <= next_st;
      end
   end

endmodule // serial_shifter

// ==== hw/codec_control_registers.sv ====
`timescale 1ns/100ps
// Operation
// (RL1) Result registers at and above the status address are read only; writes are dropped.
// (RL2) Each voice-activity level reads as two bytes, bits 15 to 8 first, then bits 7 to 0.
// (RL3) Each offset level reads as a high byte, bits 15 to 8, then a low byte, bits 7 to 0.
// (RL4) Each linear sample output reads as a 16-bit word, high byte first, then low byte.
// (RL5) The global clear is an address-only command and no data byte is taken after it.
// (RL6) The global clear forces every bit of every write-only setting register to zero.
// (RL7) Filter bandwidth bit 7 set routes the input around the anti-alias filter.
// (RL8) Filter bandwidth bits 6 to 4 set the anti-alias cutoff, codes 0 to 5 for 2.9 to 14 kHz.
// (RL9) Filter bandwidth bit 3 set bypasses the anti-image filter on the output path.
// (RL10) Filter bandwidth bits 2 to 0 pick the anti-image cutoff from the same code table.
// (RL11) Gain register bits 7 to 3 set the volume, code 0 mutes, then 1.5 dB steps from -33 dB.
// (RL12) Gain register bits 2 to 1 set sidetone gain 0, -9, -15 or -21 dB.
// (RL13) Gain register bit 0 enables the sidetone path, and clear disables it entirely.
// (RL14) Status holds encoder status in its upper half and decoder status in its lower half.
// (RL15) The host must not write codes 6 or 7 into either cutoff field.
// (RL16) Each delta-modulation output register returns one byte per read.
module codec_control_registers
   import codec_regs_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Serial control bus pins.
   input  wire logic        serial_clk,
   input  wire logic        select_b,
   input  wire logic        cmd_in,
   output logic             reply_out,
   output logic             reply_oe,
   // Results from the coding engines.
   input  wire logic [3:0]  encoder_process_status,
   input  wire logic [3:0]  decoder_process_status,
   input  wire logic [15:0] encoder_voice_activity_detector_level,
   input  wire logic [15:0] decoder_voice_activity_detector_level,
   input  wire logic [15:0] encoder_offset_level,
   input  wire logic [15:0] decoder_offset_level,
   input  wire logic [15:0] encoder_linear_sample,
   input  wire logic [15:0] decoder_linear_sample,
   input  wire logic [7:0]  encoder_delta_mod_byte,
   input  wire logic [7:0]  decoder_delta_mod_byte,
   // Settings to the analog path.
   output logic             anti_alias_filter_bypass,
   output logic [2:0]       anti_alias_filter_cutoff,
   output logic             anti_image_filter_bypass,
   output logic [2:0]       anti_image_filter_cutoff,
   output logic [4:0]       output_volume,
   output logic             output_mute,
   output logic [1:0]       sidetone_gain,
   output logic             sidetone_enable
);

   typedef struct packed {
      phase_e     phase;
      logic [7:0] addr;          // Address byte of the current frame.
      logic [7:0] filter_bw;     // Write-only filter bandwidth setting.
      logic [7:0] gain_side;     // Write-only volume and sidetone setting.
      logic [7:0] held_low;      // Low byte kept from the moment of the high byte.
      logic [1:0] bytes_sent;    // Reply bytes already loaded in this frame.
      logic       out_mute;
   } regs_s;

   regs_s st;
   regs_s next_st;

   serial_link_if link ();

   logic [15:0] read_word;
   logic        read_hit;
   logic        write_hit;

   // ****************************************************************
   // Serial bit engine
   // ****************************************************************
   serial_shifter u_shifter (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .serial_clk (serial_clk),
      .select_b   (select_b),
      .cmd_in     (cmd_in),
      .reply_out  (reply_out),
      .link       (link.shifter)
   );

   // ****************************************************************
   // Read-back decode
   // ****************************************************************

   // Only the result addresses answer a read; one-byte results sit in the
   // high half so that they go out first and a second byte reads zero.
   always_comb begin
      read_word = 16'h0000;
      read_hit  = 1'b1;
      case (link.rx_byte)
         ADDR_PROCESS_STATUS: begin
            read_word = {encoder_process_status, decoder_process_status, 8'h00}; // [RL14]
         end
         ADDR_DECODER_VOICE_ACTIVITY: begin
            read_word = decoder_voice_activity_detector_level; // [RL2]
         end
         ADDR_ENCODER_VOICE_ACTIVITY: begin
            read_word = encoder_voice_activity_detector_level; // [RL2]
         end
         ADDR_DECODER_OFFSET_RESULT: begin
            read_word = decoder_offset_level; // [RL3]
         end
         ADDR_ENCODER_OFFSET_RESULT: begin
            read_word = encoder_offset_level; // [RL3]
         end
         ADDR_DECODER_LINEAR_SAMPLE_OUT: begin
            read_word = decoder_linear_sample; // [RL4]
         end
         ADDR_ENCODER_LINEAR_SAMPLE_OUT: begin
            read_word = encoder_linear_sample; // [RL4]
         end
         ADDR_DECODER_DELTA_MOD_OUT: begin
            read_word = {decoder_delta_mod_byte, 8'h00}; // [RL16]
         end
         ADDR_ENCODER_DELTA_MOD_OUT: begin
            read_word = {encoder_delta_mod_byte, 8'h00}; // [RL16]
         end
         default: begin
            read_hit = 1'b0;
         end
      endcase
   end

   // Only the two setting registers take a data byte.
   assign write_hit = (link.rx_byte == ADDR_FILTER_BANDWIDTH_CONTROL) ||
                      (link.rx_byte == ADDR_OUTPUT_GAIN_AND_SIDETONE);

   // ****************************************************************
   // Reply loading
   // ****************************************************************

   // The high byte is loaded on the address byte, the low byte on the next
   // eighth edge; anything further shifts out zeros.
   always_comb begin
      link.tx_load = 1'b0;
      link.tx_byte = 8'h00;
      if (link.byte_valid) begin
         if (st.phase == phase_addr && read_hit) begin
            link.tx_load = 1'b1;
            link.tx_byte = read_word[15:8]; // [RL2] [RL3] [RL4]
         end else if (st.phase == phase_read) begin
            link.tx_load = 1'b1;
            link.tx_byte = (st.bytes_sent == 2'h1) ? st.held_low : 8'h00; // [RL2] [RL3] [RL4]
         end
      end
   end

   // ****************************************************************
   // Frame sequencing and setting registers
   // ****************************************************************
   always_comb begin
      next_st = st;
      if (!link.frame_active) begin
         next_st.phase      = phase_addr;
         next_st.bytes_sent = 2'h0;
      end else if (link.byte_valid) begin
         case (st.phase)
            phase_addr: begin
               next_st.addr = link.rx_byte;
               if (link.rx_byte == ADDR_GLOBAL_CLEAR) begin
                  // Clear acts on the address alone; later bytes are ignored.
                  next_st.filter_bw = WRITE_ONLY_RESET; // [RL6]
                  next_st.gain_side = WRITE_ONLY_RESET; // [RL6]
                  next_st.phase     = phase_skip;       // [RL5]
               end else if (read_hit) begin
                  // Snapshot keeps both halves of one sample together.
                  next_st.held_low   = read_word[7:0];
                  next_st.bytes_sent = 2'h1;
                  next_st.phase      = phase_read;
               end else if (write_hit) begin
                  next_st.phase = phase_write;
               end else begin
                  // Result addresses never take data, nor do unknown ones.
                  next_st.phase = phase_skip; // [RL1]
               end
            end
            phase_write: begin
               if (st.addr == ADDR_FILTER_BANDWIDTH_CONTROL) begin
                  next_st.filter_bw = link.rx_byte;
               end else begin
                  next_st.gain_side = link.rx_byte;
               end
               next_st.phase = phase_skip;
            end
            phase_read: begin
               if (st.bytes_sent != 2'h2) begin
                  next_st.bytes_sent = st.bytes_sent + 2'h1;
               end
            end
            phase_skip: begin
               next_st.phase = phase_skip;
            end
            default: begin
               next_st.phase = phase_skip;
            end
         endcase
      end
      next_st.out_mute = (next_st.gain_side[OGS_VOLUME_MSB:OGS_VOLUME_LSB] ==
                          VOLUME_MUTE_CODE); // [RL11]
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{phase: phase_addr, out_mute: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Setting outputs
   // ****************************************************************

   // Cutoff codes 6 and 7 are passed through unchanged; the analog filter
   // decides what they mean, so the host is expected to avoid them.
   assign anti_alias_filter_bypass = st.filter_bw[FBW_AAF_BYPASS_BIT];                  // [RL7]
   assign anti_alias_filter_cutoff = st.filter_bw[FBW_AAF_CUT_MSB:FBW_AAF_CUT_LSB];     // [RL8]
   assign anti_image_filter_bypass = st.filter_bw[FBW_AIF_BYPASS_BIT];                  // [RL9]
   assign anti_image_filter_cutoff = st.filter_bw[FBW_AIF_CUT_MSB:FBW_AIF_CUT_LSB];     // [RL10]
   assign output_volume            = st.gain_side[OGS_VOLUME_MSB:OGS_VOLUME_LSB];       // [RL11]
   assign output_mute              = st.out_mute;                                       // [RL11]
   assign sidetone_gain            = st.gain_side[OGS_SIDETONE_MSB:OGS_SIDETONE_LSB];   // [RL12]
   assign sidetone_enable          = st.gain_side[OGS_SIDETONE_EN_BIT];                 // [RL13]

   // The reply pin is driven only while a read frame is open.
   assign reply_oe = link.frame_active && (st.phase == phase_read);

endmodule // codec_control_registers

// ==== dv/serial_host.sv ====
`timescale 1ns/100ps
module serial_host
   import codec_regs_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reply_out,
   output logic      serial_clk,
   output logic      select_b,
   output logic      cmd_in
);
   // ******************************
   // Host end of the control bus
   // ******************************

   // Idle: no frame, link clock low.
   initial begin
      serial_clk = 1'b0;
      select_b   = 1'b1;
      cmd_in     = 1'b0;
   end

   // Four system clocks per half bit give the 200 ns link period.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         cmd_in = tx[i];
         repeat (4) @(negedge mclk);
         serial_clk = 1'b1;
         repeat (4) @(negedge mclk);
         rx[i] = reply_out; // Taken late in the high half, clear of the sync delay.
         serial_clk = 1'b0;
      end
   endtask

   // One frame: command byte, then n bytes; read bytes collect into r.
   task automatic frame(input logic [7:0] a, input int n, input logic [7:0] d,
                        output logic [15:0] r);
      logic [7:0] x;
      r = 16'h0000;
      select_b = 1'b0;
      repeat (4) @(negedge mclk);
      xfer(a, x);
      for (int k = 0; k < n; k++) begin
         xfer(d, x);
         r = {r[7:0], x};
      end
      repeat (4) @(negedge mclk);
      select_b = 1'b1;
      cmd_in   = ~cmd_in; // A released line must not keep showing the last bit.
      repeat (6) @(negedge mclk);
   endtask
endmodule // serial_host

// ==== dv/codec_control_registers_asserts.sv ====
`timescale 1ns/100ps
module codec_control_registers_asserts
   import codec_regs_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       serial_clk,
   input wire logic       select_b,
   input wire logic       cmd_in,
   input wire logic       reply_oe,
   input wire logic       anti_alias_filter_bypass,
   input wire logic [2:0] anti_alias_filter_cutoff,
   input wire logic       anti_image_filter_bypass,
   input wire logic [2:0] anti_image_filter_cutoff,
   input wire logic [4:0] output_volume,
   input wire logic       output_mute,
   input wire logic [1:0] sidetone_gain,
   input wire logic       sidetone_enable
);
   // ******************************
   // Frame tracker
   // ******************************
   logic [2:0]  sck_q;
   logic [1:0]  sel_q;
   logic [2:0]  bit_cnt;
   logic [1:0]  nbyte;
   logic [7:0]  sh;
   logic [7:0]  addr;
   logic        done;
   logic [15:0] sets;

   // All settings but output_mute, in register order, so one compare covers them.
   assign sets = {anti_alias_filter_bypass, anti_alias_filter_cutoff, anti_image_filter_bypass,
                  anti_image_filter_cutoff, output_volume, sidetone_gain, sidetone_enable};

   // Own synchroniser on clock and select, matching the device stage for stage, with cmd_in taken raw; done trails byte_valid by a cycle, hence the ranges below.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sck_q   <= 3'h0;
         sel_q   <= 2'h3;
         bit_cnt <= 3'h0;
         nbyte   <= 2'h0;
         sh      <= 8'h00;
         addr    <= 8'h00;
         done    <= 1'b0;
      end else begin
         sck_q <= {sck_q[1:0], serial_clk};
         sel_q <= {sel_q[0], select_b};
         done  <= 1'b0;
         if (sel_q[1]) begin
            bit_cnt <= 3'h0;
            nbyte   <= 2'h0;
         end else if (sck_q[1] && !sck_q[2]) begin
            sh      <= {sh[6:0], cmd_in};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT_OF_BYTE) begin
               done  <= 1'b1;
               nbyte <= (nbyte == 2'h3) ? nbyte : nbyte + 2'h1;
               if (nbyte == 2'h0) begin
                  addr <= {sh[6:0], cmd_in};
               end
            end
         end
      end
   end

   // ******************************
   // Properties
   // ******************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_byte(logic [1:0] n, logic [7:0] a);
      done && nbyte == n && addr == a;
   endsequence
   sequence s_fbw; s_byte(2'h2, ADDR_FILTER_BANDWIDTH_CONTROL); endsequence
   sequence s_ogs; s_byte(2'h2, ADDR_OUTPUT_GAIN_AND_SIDETONE); endsequence
   // Every result register sits at or above the status address; this takes every such address as one.
   sequence s_result(logic [1:0] n);
      done && nbyte == n && addr >= ADDR_PROCESS_STATUS;
   endsequence

   property p_clear; s_byte(2'h1, ADDR_GLOBAL_CLEAR) |-> ##[0:3] sets == 16'h0000; endproperty
   a_clear: assert property (p_clear) else $error("clear left a setting");
   property p_aa_byp; s_fbw |-> ##[0:3] anti_alias_filter_bypass == sh[7]; endproperty
   a_aa_byp: assert property (p_aa_byp) else $error("alias bypass wrong");
   property p_aa_cut; s_fbw |-> ##[0:3] anti_alias_filter_cutoff == sh[6:4]; endproperty
   a_aa_cut: assert property (p_aa_cut) else $error("alias cutoff wrong");
   property p_ai_byp; s_fbw |-> ##[0:3] anti_image_filter_bypass == sh[3]; endproperty
   a_ai_byp: assert property (p_ai_byp) else $error("image bypass wrong");
   property p_ai_cut; s_fbw |-> ##[0:3] anti_image_filter_cutoff == sh[2:0]; endproperty
   a_ai_cut: assert property (p_ai_cut) else $error("image cutoff wrong");
   property p_vol;
      s_ogs |-> ##[0:3] (output_volume == sh[7:3] && output_mute == (sh[7:3] == VOLUME_MUTE_CODE));
   endproperty
   a_vol: assert property (p_vol) else $error("volume wrong");
   property p_st_gain; s_ogs |-> ##[0:3] sidetone_gain == sh[2:1]; endproperty
   a_st_gain: assert property (p_st_gain) else $error("sidetone gain wrong");
   property p_st_en; s_ogs |-> ##[0:3] sidetone_enable == sh[0]; endproperty
   a_st_en: assert property (p_st_en) else $error("sidetone enable wrong");
   property p_ro; s_result(2'h2) |=> $stable(sets)[*4]; endproperty
   a_ro: assert property (p_ro) else $error("result write changed a setting");
   // A read address must open the reply driver before the first reply bit goes out.
   property p_oe; s_result(2'h1) |-> ##[0:3] reply_oe; endproperty
   a_oe: assert property (p_oe) else $error("reply not enabled for a read");
   property p_no_oe; s_fbw or s_ogs |-> ##[0:3] !reply_oe; endproperty
   a_no_oe: assert property (p_no_oe) else $error("reply enabled for a write");
   property p_no_data; s_byte(2'h2, ADDR_GLOBAL_CLEAR) |=> $stable(sets)[*4]; endproperty
   a_no_data: assert property (p_no_data) else $error("byte after clear taken");
endmodule // codec_control_registers_asserts

// ==== dv/codec_control_registers_tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module codec_control_registers_tb
   import codec_regs_pkg::*;
;
   // ******************************
   // Bench signals and result values
   // ******************************
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        serial_clk, select_b, cmd_in, reply_out, reply_oe;
   logic [3:0]  enc_st = 4'hA, dec_st = 4'h5;
   logic [15:0] enc_vad = 16'h1234, dec_vad = 16'hA55A, enc_off = 16'h8001;
   logic [15:0] dec_off = 16'h7FFE, enc_lin = 16'hC3E1, dec_lin = 16'h0F96;
   logic [7:0]  enc_dm = 8'h6D, dec_dm = 8'hB2, d;
   logic        aa_b, ai_b, mute, st_en;
   logic [2:0]  aa_c, ai_c;
   logic [4:0]  vol;
   logic [1:0]  st_g;
   logic [15:0] sets, rd;
   logic [4:0]  vols [4] = '{5'h00, 5'h01, 5'h10, 5'h1F};
   logic [7:0]  rds [11] = '{8'h80, 8'hD4, 8'hD5, 8'hD6, 8'hDA, 8'hE4, 8'hE5, 8'hE6, 8'hEA,
                           8'h61, 8'h62};
   int          fails = 0, checks = 0;

   assign sets = {aa_b, aa_c, ai_b, ai_c, vol, st_g, st_en};

   codec_control_registers u_dut (.mclk(mclk), .rst_b(rst_b), .serial_clk(serial_clk),
      .select_b(select_b), .cmd_in(cmd_in), .reply_out(reply_out), .reply_oe(reply_oe),
      .encoder_process_status(enc_st), .decoder_process_status(dec_st),
      .encoder_voice_activity_detector_level(enc_vad),
      .decoder_voice_activity_detector_level(dec_vad),
      .encoder_offset_level(enc_off), .decoder_offset_level(dec_off),
      .encoder_linear_sample(enc_lin), .decoder_linear_sample(dec_lin),
      .encoder_delta_mod_byte(enc_dm), .decoder_delta_mod_byte(dec_dm),
      .anti_alias_filter_bypass(aa_b), .anti_alias_filter_cutoff(aa_c),
      .anti_image_filter_bypass(ai_b), .anti_image_filter_cutoff(ai_c),
      .output_volume(vol), .output_mute(mute), .sidetone_gain(st_g), .sidetone_enable(st_en));

   serial_host u_host (.mclk(mclk), .reply_out(reply_out), .serial_clk(serial_clk),
      .select_b(select_b), .cmd_in(cmd_in));

   // 40 MHz system clock.
   always #12.5 mclk = ~mclk;

   // Expected two-byte reply: 8-bit results pad with a zero byte.
   function automatic logic [15:0] exp_read(input logic [7:0] a);
      case (a)
         ADDR_PROCESS_STATUS:           return {enc_st, dec_st, 8'h00};
         ADDR_DECODER_VOICE_ACTIVITY:   return dec_vad;
         ADDR_DECODER_OFFSET_RESULT:    return dec_off;
         ADDR_DECODER_LINEAR_SAMPLE_OUT: return dec_lin;
         ADDR_DECODER_DELTA_MOD_OUT:    return {dec_dm, 8'h00};
         ADDR_ENCODER_VOICE_ACTIVITY:   return enc_vad;
         ADDR_ENCODER_OFFSET_RESULT:    return enc_off;
         ADDR_ENCODER_LINEAR_SAMPLE_OUT: return enc_lin;
         ADDR_ENCODER_DELTA_MOD_OUT:    return {enc_dm, 8'h00};
         default:                       return 16'h0000;
      endcase
   endfunction

   // Single exit point for both the normal end and the watchdog.
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // A full run is about 5300 cycles; this leaves ample room.
   initial begin
      repeat (30000) @(posedge mclk);
      fails++;
      end_of_test();
   end

   // ******************************
   // Test sequence
   // ******************************
   initial begin
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      `CHK({sets, mute, reply_oe}, {16'h0000, 1'b1, 1'b0})
      for (int c = 0; c < 6; c++) begin
         d = {c[0], c[2:0], ~c[0], 3'(5 - c)}; // Cutoff codes kept within 0 to 5.
         u_host.frame(ADDR_FILTER_BANDWIDTH_CONTROL, 1, d, rd);
         `CHK(sets[15:8], d)
      end
      for (int i = 0; i < 4; i++) begin
         d = {vols[i], i[1:0], i[0]};
         u_host.frame(ADDR_OUTPUT_GAIN_AND_SIDETONE, 1, d, rd);
         `CHK({sets[7:0], mute}, {d, vols[i] == VOLUME_MUTE_CODE})
      end
      // Writes aimed at result addresses must be dropped.
      for (int i = 0; i < 9; i++) begin
         u_host.frame(rds[i], 1, 8'h3C, rd);
      end
      `CHK(sets, 16'hD0FF)
      for (int i = 0; i < 11; i++) begin
         u_host.frame(rds[i], 2, 8'h00, rd);
         `CHK(rd, exp_read(rds[i]))
      end
      u_host.frame(ADDR_GLOBAL_CLEAR, 0, 8'h00, rd);
      `CHK({sets, mute}, {16'h0000, 1'b1})
      u_host.frame(ADDR_FILTER_BANDWIDTH_CONTROL, 1, 8'h35, rd);
      // Host misbehaves on purpose: a data byte trails the clear.
      u_host.frame(ADDR_GLOBAL_CLEAR, 1, 8'h35, rd);
      `CHK(sets, 16'h0000)
      end_of_test();
   end
endmodule // codec_control_registers_tb

bind codec_control_registers codec_control_registers_asserts u_chk (.*);
